// ===== hw/fpcc_pkg.sv
// constants for the flash program command controller
package fpcc_pkg;
	// register offsets (byte addresses)
	localparam logic [7:0] REG_STAT = 8'h00;
	localparam logic [7:0] REG_COB0 = 8'h04;
	localparam logic [7:0] REG_COB1 = 8'h08;
	localparam logic [7:0] REG_COB2 = 8'h0c;
	localparam logic [7:0] REG_CTRL = 8'h10;
	localparam logic [7:0] REG_CFG0 = 8'h14;
	localparam logic [7:0] REG_CFG1 = 8'h18;
	localparam logic [7:0] REG_CFG2 = 8'h1c;
	localparam logic [7:0] REG_CFG3 = 8'h20;
	localparam logic [7:0] REG_PART = 8'h24;
	localparam logic [7:0] REG_IRQ_ST = 8'h28;
	localparam logic [7:0] REG_IRQ_CLR = 8'h2c;
	localparam logic [7:0] REG_IRQ_EN = 8'h30;
	// field positions
	localparam int STAT_CCF = 7;
	localparam int STAT_ACCERR = 5;
	localparam int CTRL_EEMODE = 0;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_ERR = 1;
	localparam int IRQ_REJ = 2;
	localparam int IRQ_W = 3;
	// command codes in the top byte of command object word 0
	localparam logic [7:0] CMD_PGM_LONG = 8'h01;
	localparam logic [7:0] CMD_PGM_PHRASE = 8'h02;
	localparam logic [7:0] CMD_PGM_SECT = 8'h03;
	localparam logic [7:0] CMD_PART = 8'h04;
	localparam logic [7:0] CMD_MASS = 8'h05;
	// variant: port present, section present, phrase (not longword) program
	localparam logic HAS_PORT = 1'b1;
	localparam logic HAS_SECT = 1'b1;
	localparam logic HAS_PHRASE = 1'b1;
	localparam logic CTRL_QUARTER = 1'b1;
	// section length: lesser of sector and a fraction of the staging ram
	localparam int SECTOR_BYTES = 2048;
	localparam int STAGE_RAM_BYTES = 4096;
	localparam int RAM_SHARE = CTRL_QUARTER ? STAGE_RAM_BYTES / 4 : STAGE_RAM_BYTES / 2;
	localparam int SECT_BYTES = (SECTOR_BYTES < RAM_SHARE) ? SECTOR_BYTES : RAM_SHARE;
	localparam logic [9:0] SECT_WORDS = 10'(SECT_BYTES / 4);
	localparam logic [9:0] LONG_WORDS = 10'h001;
	localparam logic [9:0] PHRASE_WORDS = 10'h002;
	// configuration area and partition record
	localparam logic [23:0] CFG_BASE = 24'h000400;
	localparam logic [23:0] PART_ADDR = 24'h000800;
	localparam logic [2:0] LOAD_LAST = 3'h5;
	localparam logic [31:0] BLANK_WORD = 32'hffffffff;
	// serial port opcodes and frame lengths
	localparam logic [7:0] SP_OP_RDSR = 8'h11;
	localparam logic [7:0] SP_OP_SECT = 8'h12;
	localparam logic [7:0] SP_OP_WRCOB = 8'h13;
	localparam logic [3:0] SP_SECT_LAST = 4'h3;
	localparam logic [3:0] SP_COB_LAST = 4'hc;
	typedef enum logic [1:0] {FOP_PROG, FOP_ERASE_NVM, FOP_FORMAT, FOP_ERASE_ALL} fpcc_fop_e;
endpackage : fpcc_pkg

// ===== hw/fpcc_top.sv
// flash program command controller: register port, serial port, command sequencer
//
// Behaviour
// - only one of longword or phrase program exists; the other is rejected.
// - section length is the lesser of sector size and ram share.
// - section programming needs the staging ram in plain ram mode.
// - entering serial port mode forces plain ram mode; port programs by sections.
// - port section program is refused while the staging ram is in eeprom mode.
// - longword and phrase data come from command object registers, not the ram.
// - a variant without the serial port also lacks section programming.
// - at reset the 16-byte configuration area is copied into registers.
// - new configuration values act only after the next reset load.
// - a blank device has no eeprom partition.
// - partition erases the whole region, then formats the backup sectors.
// - port partitions through its command object write opcode.
// - mass erase discards partition and eeprom records.
// - port status shows write in progress while an operation runs.
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/100ps
module fpcc_top (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic irq,
	output logic [23:0] flash_rd_addr,
	input wire logic [31:0] flash_rd_data,
	output logic fop_start,
	output fpcc_pkg::fpcc_fop_e fop_kind,
	output logic [23:0] fop_addr,
	output logic [63:0] fop_data,
	output logic [9:0] fop_len,
	output logic fop_use_ram,
	input wire logic fop_done,
	output logic ram_eeprom_mode,
	output logic eeprom_part_en,
	output logic [31:0] prot_ctrl,
	output logic [7:0] sec_ctrl,
	input wire logic sp_mode,
	input wire logic sp_cs_n,
	input wire logic sp_clk,
	input wire logic sp_din,
	output logic sp_dout,
	output logic sp_dout_oe
);
	typedef enum logic [2:0] {S_LOAD, S_IDLE, S_OP, S_PART1, S_PART2} fpcc_state_e;
	fpcc_state_e st_r;
	logic [2:0] ld_cnt_r;
	logic [31:0] cfg_r [4];
	logic [31:0] part_r;
	logic [31:0] cob_r [3];
	logic ccf_r, acc_err_r, pend_r, ee_mode_r;
	localparam int IRQ_W_L = fpcc_pkg::IRQ_W - 1;
	logic [IRQ_W_L:0] irq_st_r, irq_en_r;
	logic [31:0] rd_mux;
	logic [3:0] sync1_r, sync2_r;
	logic sp_clk_d_r, sp_mode_d_r;
	logic [2:0] sp_bit_r;
	logic [3:0] sp_byte_r;
	logic [7:0] sp_sh_r, sp_op_r, sp_tx_r;
	logic [87:0] sp_buf_r;
	logic [7:0] sp_byte;
	logic sp_rise, sp_act, sp_done_byte, sp_sect_go, sp_cob_go, sp_reject;
	logic reg_launch, launch_acc, cmd_ok, done_set, err_set, busy;
	logic [7:0] cmd;
	logic [7:0] sp_status;
	logic [IRQ_W_L:0] irq_ev;

	// two-flop synchronisers for the serial port pins
	always_ff @(posedge sys_clk) begin
		sync1_r <= {sp_mode, sp_cs_n, sp_clk, sp_din};
		sync2_r <= sync1_r;
		sp_clk_d_r <= sync2_r[1];
		sp_mode_d_r <= sync2_r[3];
	end

	assign sp_act = ~sync2_r[2];
	assign sp_rise = sync2_r[1] & ~sp_clk_d_r;
	assign sp_byte = {sp_sh_r[6:0], sync2_r[0]};
	assign sp_done_byte = sp_act & sp_rise & (sp_bit_r == 3'h7);
	assign sp_sect_go = sp_done_byte & (sp_op_r == fpcc_pkg::SP_OP_SECT)
		& (sp_byte_r == fpcc_pkg::SP_SECT_LAST) & fpcc_pkg::HAS_PORT;
	assign sp_cob_go = sp_done_byte & (sp_op_r == fpcc_pkg::SP_OP_WRCOB)
		& (sp_byte_r == fpcc_pkg::SP_COB_LAST) & fpcc_pkg::HAS_PORT;
	assign sp_reject = sp_sect_go & ee_mode_r;
	assign busy = (st_r != S_IDLE) | pend_r;
	assign sp_status = {6'h00, ee_mode_r, busy};

	// serial frame receiver and status transmitter
	always_ff @(posedge sys_clk) begin
		if (srst || !sp_act) begin
			sp_bit_r <= 3'h0;
			sp_byte_r <= 4'h0;
			sp_op_r <= 8'h00;
			sp_sh_r <= 8'h00;
			sp_tx_r <= 8'h00;
			sp_buf_r <= 88'h0;
			sp_dout <= 1'b0;
			sp_dout_oe <= 1'b0;
		end else if (sp_rise) begin
			sp_bit_r <= sp_bit_r + 3'h1;
			sp_sh_r <= sp_byte;
			if (sp_bit_r == 3'h7) begin
				if (sp_byte_r != 4'hf)
					sp_byte_r <= sp_byte_r + 4'h1;
				if (sp_byte_r == 4'h0)
					sp_op_r <= sp_byte;
				else
					sp_buf_r <= {sp_buf_r[79:0], sp_byte};
			end
			// status repeats every byte while reading status
			if ((sp_bit_r == 3'h7) && (((sp_byte_r == 4'h0) && (sp_byte == fpcc_pkg::SP_OP_RDSR))
				|| ((sp_byte_r != 4'h0) && (sp_op_r == fpcc_pkg::SP_OP_RDSR)))) begin
				sp_dout <= sp_status[7];
				sp_tx_r <= {sp_status[6:0], 1'b0};
				sp_dout_oe <= 1'b1;
			end else begin
				sp_dout <= sp_tx_r[7];
				sp_tx_r <= {sp_tx_r[6:0], 1'b0};
			end
		end
	end

	// staging ram mode: port entry forces plain ram mode
	always_ff @(posedge sys_clk) begin
		if (srst)
			ee_mode_r <= 1'b0;
		else if (sync2_r[3] && !sp_mode_d_r)
			ee_mode_r <= 1'b0;
		else if (reg_wr && reg_addr == fpcc_pkg::REG_CTRL)
			ee_mode_r <= reg_wdata[fpcc_pkg::CTRL_EEMODE];
	end
	assign ram_eeprom_mode = ee_mode_r;

	// launch requests from either side; register side wins a tie
	assign reg_launch = reg_wr && (reg_addr == fpcc_pkg::REG_STAT)
		&& reg_wdata[fpcc_pkg::STAT_CCF];
	assign launch_acc = ccf_r && (reg_launch || sp_cob_go || (sp_sect_go && !ee_mode_r));

	// command object registers, locked while a command is pending or running
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cob_r[0] <= 32'h0;
			cob_r[1] <= 32'h0;
			cob_r[2] <= 32'h0;
		end else if (ccf_r && reg_wr) begin
			if (reg_addr == fpcc_pkg::REG_COB0) cob_r[0] <= reg_wdata;
			if (reg_addr == fpcc_pkg::REG_COB1) cob_r[1] <= reg_wdata;
			if (reg_addr == fpcc_pkg::REG_COB2) cob_r[2] <= reg_wdata;
		end else if (ccf_r && sp_cob_go) begin
			cob_r[0] <= sp_buf_r[87:56];
			cob_r[1] <= sp_buf_r[55:24];
			cob_r[2] <= {sp_buf_r[23:0], sp_byte};
		end else if (ccf_r && sp_sect_go && !ee_mode_r) begin
			cob_r[0] <= {fpcc_pkg::CMD_PGM_SECT, sp_buf_r[15:0], sp_byte};
		end
	end

	// command decode against the variant
	assign cmd = cob_r[0][31:24];
	always_comb begin
		unique case (cmd)
			fpcc_pkg::CMD_PGM_LONG: cmd_ok = !fpcc_pkg::HAS_PHRASE;
			fpcc_pkg::CMD_PGM_PHRASE: cmd_ok = fpcc_pkg::HAS_PHRASE;
			fpcc_pkg::CMD_PGM_SECT: cmd_ok = fpcc_pkg::HAS_SECT && fpcc_pkg::HAS_PORT
				&& !ee_mode_r;
			fpcc_pkg::CMD_PART: cmd_ok = 1'b1;
			fpcc_pkg::CMD_MASS: cmd_ok = 1'b1;
			default: cmd_ok = 1'b0;
		endcase
	end
	assign err_set = (st_r == S_IDLE) && pend_r && !cmd_ok;
	assign done_set = fop_done && ((st_r == S_OP) || (st_r == S_PART2));

	// configuration load after reset; values change only here
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ld_cnt_r <= 3'h0;
			flash_rd_addr <= fpcc_pkg::CFG_BASE;
		end else if (st_r == S_LOAD) begin
			ld_cnt_r <= ld_cnt_r + 3'h1;
			// data lag the address by one edge, so the address runs one word ahead
			flash_rd_addr <= (ld_cnt_r < 3'h3)
				? fpcc_pkg::CFG_BASE + {19'h0, ld_cnt_r + 3'h1, 2'h0}
				: fpcc_pkg::PART_ADDR;
			if (ld_cnt_r != 3'h0 && ld_cnt_r < 3'h5)
				cfg_r[ld_cnt_r[1:0] - 2'h1] <= flash_rd_data;
		end
	end
	assign prot_ctrl = cfg_r[0];
	assign sec_ctrl = cfg_r[3][7:0];

	// command sequencer
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_r <= S_LOAD;
			ccf_r <= 1'b0;
			pend_r <= 1'b0;
			acc_err_r <= 1'b0;
			part_r <= fpcc_pkg::BLANK_WORD;
			fop_start <= 1'b0;
			fop_kind <= fpcc_pkg::FOP_PROG;
			fop_addr <= 24'h0;
			fop_data <= 64'h0;
			fop_len <= 10'h0;
			fop_use_ram <= 1'b0;
		end else begin
			fop_start <= 1'b0;
			if (reg_wr && reg_addr == fpcc_pkg::REG_STAT && reg_wdata[fpcc_pkg::STAT_ACCERR])
				acc_err_r <= 1'b0;
			if (launch_acc) begin
				ccf_r <= 1'b0;
				pend_r <= 1'b1;
			end
			unique case (st_r)
				S_LOAD: if (ld_cnt_r == fpcc_pkg::LOAD_LAST) begin
					part_r <= flash_rd_data;
					ccf_r <= 1'b1;
					st_r <= S_IDLE;
				end
				S_IDLE: if (pend_r) begin
					pend_r <= 1'b0;
					fop_addr <= cob_r[0][23:0];
					fop_use_ram <= 1'b0;
					if (!cmd_ok) begin
						acc_err_r <= 1'b1;
						ccf_r <= 1'b1;
					end else begin
						fop_start <= 1'b1;
						st_r <= S_OP;
						unique case (cmd)
							fpcc_pkg::CMD_PGM_LONG: begin
								fop_kind <= fpcc_pkg::FOP_PROG;
								fop_data <= {32'h0, cob_r[1]};
								fop_len <= fpcc_pkg::LONG_WORDS;
							end
							fpcc_pkg::CMD_PGM_PHRASE: begin
								fop_kind <= fpcc_pkg::FOP_PROG;
								fop_data <= {cob_r[2], cob_r[1]};
								fop_len <= fpcc_pkg::PHRASE_WORDS;
							end
							fpcc_pkg::CMD_PGM_SECT: begin
								fop_kind <= fpcc_pkg::FOP_PROG;
								fop_use_ram <= 1'b1;
								fop_len <= fpcc_pkg::SECT_WORDS;
							end
							fpcc_pkg::CMD_PART: begin
								fop_kind <= fpcc_pkg::FOP_ERASE_NVM;
								st_r <= S_PART1;
							end
							default: fop_kind <= fpcc_pkg::FOP_ERASE_ALL;
						endcase
					end
				end
				S_PART1: if (fop_done) begin
					fop_kind <= fpcc_pkg::FOP_FORMAT;
					fop_start <= 1'b1;
					st_r <= S_PART2;
				end
				S_PART2: if (fop_done) begin
					part_r <= cob_r[1];
					ccf_r <= 1'b1;
					st_r <= S_IDLE;
				end
				S_OP: if (fop_done) begin
					if (cmd == fpcc_pkg::CMD_MASS)
						part_r <= fpcc_pkg::BLANK_WORD;
					ccf_r <= 1'b1;
					st_r <= S_IDLE;
				end
			endcase
		end
	end
	assign eeprom_part_en = (part_r != fpcc_pkg::BLANK_WORD);

	// interrupt status, enable and write-one clear; a new event wins over its clear
	assign irq_ev = {sp_reject, err_set, done_set};
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			irq_st_r <= '0;
			irq_en_r <= '0;
		end else begin
			if (reg_wr && reg_addr == fpcc_pkg::REG_IRQ_EN)
				irq_en_r <= reg_wdata[IRQ_W_L:0];
			if (reg_wr && reg_addr == fpcc_pkg::REG_IRQ_CLR)
				irq_st_r <= (irq_st_r & ~reg_wdata[IRQ_W_L:0]) | irq_ev;
			else
				irq_st_r <= irq_st_r | irq_ev;
		end
	end
	assign irq = |(irq_st_r & irq_en_r);

	// read mux; unmapped and write-only offsets read zero
	always_comb begin
		unique case (reg_addr)
			fpcc_pkg::REG_STAT: rd_mux = {24'h0, ccf_r, 1'b0, acc_err_r, 5'h00};
			fpcc_pkg::REG_COB0: rd_mux = cob_r[0];
			fpcc_pkg::REG_COB1: rd_mux = cob_r[1];
			fpcc_pkg::REG_COB2: rd_mux = cob_r[2];
			fpcc_pkg::REG_CTRL: rd_mux = {31'h0, ee_mode_r};
			fpcc_pkg::REG_CFG0: rd_mux = cfg_r[0];
			fpcc_pkg::REG_CFG1: rd_mux = cfg_r[1];
			fpcc_pkg::REG_CFG2: rd_mux = cfg_r[2];
			fpcc_pkg::REG_CFG3: rd_mux = cfg_r[3];
			fpcc_pkg::REG_PART: rd_mux = part_r;
			fpcc_pkg::REG_IRQ_ST: rd_mux = {29'h0, irq_st_r};
			fpcc_pkg::REG_IRQ_EN: rd_mux = {29'h0, irq_en_r};
			default: rd_mux = 32'h0;
		endcase
	end
	always_ff @(posedge sys_clk) begin
		if (srst)
			reg_rdata <= 32'h0;
		else if (reg_rd)
			reg_rdata <= rd_mux;
		else
			reg_rdata <= 32'h0;
	end

	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);
	ccf_launch_a: assert property (launch_acc |=> !ccf_r
		##1 (!ccf_r || (acc_err_r && !fop_start)))
		else $error("ccf not cleared at launch");
	ccf_hold_a: assert property ((st_r == S_OP || st_r == S_PART1) |-> !ccf_r && busy)
		else $error("ccf set while operation runs");
	cfg_stable_a: assert property ((st_r != S_LOAD) |=> $stable(cfg_r[0]) && $stable(cfg_r[3]))
		else $error("configuration changed outside reset load");
	load_len_a: assert property ($fell(srst) |-> (st_r == S_LOAD) [*6] ##1 ccf_r)
		else $error("configuration load length wrong");
	sect_len_a: assert property (fop_start && fop_use_ram |-> fop_len == fpcc_pkg::SECT_WORDS
		&& !ee_mode_r)
		else $error("section length or ram mode wrong");
	phrase_data_a: assert property ((st_r == S_IDLE && pend_r && cmd_ok
		&& cmd == fpcc_pkg::CMD_PGM_PHRASE) |=> fop_start && !fop_use_ram
		&& fop_data == {cob_r[2], cob_r[1]})
		else $error("phrase data not from command object");
	long_rej_a: assert property ((st_r == S_IDLE && pend_r && cmd == fpcc_pkg::CMD_PGM_LONG)
		|=> acc_err_r && ccf_r && !fop_start)
		else $error("unsupported longword accepted");
	port_rej_a: assert property (sp_reject |=> !pend_r ##1 !fop_start)
		else $error("section launched in eeprom mode");
	port_ram_a: assert property (sync2_r[3] && !sp_mode_d_r |=> !ee_mode_r)
		else $error("port entry did not force ram mode");
	part_seq_a: assert property ((st_r == S_PART1 && fop_done) |=> fop_start
		&& fop_kind == fpcc_pkg::FOP_FORMAT && !ccf_r)
		else $error("partition did not format after erase");
	mass_clr_a: assert property ((st_r == S_OP && fop_done && cmd == fpcc_pkg::CMD_MASS)
		|=> !eeprom_part_en)
		else $error("mass erase kept partition");
	wip_a: assert property (fop_start |-> sp_status[0] [*2])
		else $error("write in progress not shown");
	sect_c: cover property (fop_start && fop_use_ram ##[1:1000] done_set);
	part_c: cover property (st_r == S_PART2 && fop_done);
	rej_c: cover property (sp_reject);
	cob_c: cover property (sp_cob_go && ccf_r);
endmodule : fpcc_top

// ===== verif/fpcc_flash_model.sv
// flash array model: config area, partition record and timed operations
`timescale 1ns/100ps
module fpcc_flash_model (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [23:0] flash_rd_addr,
	output logic [31:0] flash_rd_data,
	input wire logic fop_start,
	input wire fpcc_pkg::fpcc_fop_e fop_kind,
	input wire logic [23:0] fop_addr,
	input wire logic [63:0] fop_data,
	input wire logic [7:0] delay,
	output logic fop_done
);
	// nonvolatile contents survive srst; word 0 protects, word 3 secures
	logic [31:0] cfg [4] = '{32'h000000f0, 32'hffffffff, 32'hffffffff, 32'hffffff5a};
	logic [31:0] part = 32'hffffffff; // blank part: no eeprom partition
	logic [7:0] cnt;
	// reads answer the cycle after the address, erased flash reads all ones
	always @(posedge sys_clk) begin
		if (flash_rd_addr[23:4] == 20'h00040) flash_rd_data <= cfg[flash_rd_addr[3:2]];
		else if (flash_rd_addr == fpcc_pkg::PART_ADDR) flash_rd_data <= part;
		else flash_rd_data <= fpcc_pkg::BLANK_WORD;
	end
	// each operation ends delay cycles after its start; slow or prompt per bench
	always @(posedge sys_clk) begin
		fop_done <= 1'b0;
		if (srst) begin
			cnt <= 8'h00;
		end else if (fop_start) begin
			cnt <= delay;
		end else if (cnt != 8'h00) begin
			cnt <= cnt - 8'h01;
			if (cnt == 8'h01) begin
				fop_done <= 1'b1;
				if (fop_kind == fpcc_pkg::FOP_PROG && fop_addr[23:4] == 20'h00040) begin
					cfg[fop_addr[3:2]] <= fop_data[31:0];
					cfg[fop_addr[3:2] + 2'h1] <= fop_data[63:32];
				end
				if (fop_kind == fpcc_pkg::FOP_ERASE_NVM || fop_kind == fpcc_pkg::FOP_ERASE_ALL) begin
					part <= fpcc_pkg::BLANK_WORD; // region erase drops the record
				end
			end
		end
	end
endmodule : fpcc_flash_model

// ===== verif/tb_fpcc_top.sv
// self-checking bench for the flash program command controller
`timescale 1ns/100ps
module tb_fpcc_top;
	logic sys_clk, srst, reg_wr, reg_rd, fop_start, fop_use_ram, fop_done, irq, u_last;
	logic ram_eeprom_mode, eeprom_part_en, sp_mode, sp_cs_n, sp_clk, sp_din, sp_dout, sp_dout_oe;
	logic [7:0] reg_addr, sec_ctrl, delay, sb;
	logic [31:0] reg_wdata, reg_rdata, flash_rd_data, prot_ctrl, rv;
	logic [23:0] flash_rd_addr, fop_addr, a_last;
	logic sb_oe;
	logic [63:0] fop_data, d_last;
	logic [9:0] fop_len, l_last;
	fpcc_pkg::fpcc_fop_e fop_kind, k_prev, k_last;
	int n_errors, num_checks, n_starts;
	fpcc_top dut (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
		.flash_rd_addr(flash_rd_addr), .flash_rd_data(flash_rd_data), .fop_start(fop_start),
		.fop_kind(fop_kind), .fop_addr(fop_addr), .fop_data(fop_data), .fop_len(fop_len),
		.fop_use_ram(fop_use_ram), .fop_done(fop_done), .ram_eeprom_mode(ram_eeprom_mode),
		.eeprom_part_en(eeprom_part_en), .prot_ctrl(prot_ctrl), .sec_ctrl(sec_ctrl),
		.sp_mode(sp_mode), .sp_cs_n(sp_cs_n), .sp_clk(sp_clk), .sp_din(sp_din),
		.sp_dout(sp_dout), .sp_dout_oe(sp_dout_oe));
	fpcc_flash_model flash (.sys_clk(sys_clk), .srst(srst), .flash_rd_addr(flash_rd_addr),
		.flash_rd_data(flash_rd_data), .fop_start(fop_start), .fop_kind(fop_kind),
		.fop_addr(fop_addr), .fop_data(fop_data), .delay(delay), .fop_done(fop_done));
	// 20 MHz system clock
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	// record each operation launched towards the flash array
	always @(posedge sys_clk) begin
		if (fop_start === 1'b1) begin
			n_starts <= n_starts + 1;
			k_prev <= k_last;
			k_last <= fop_kind;
			d_last <= fop_data;
			a_last <= fop_addr;
			l_last <= fop_len;
			u_last <= fop_use_ram;
		end
	end
	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : summarize
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic timeout(input string what);
		n_errors++;
		$display("[ERR] %s expected completion seen none", what);
		summarize();
	endtask : timeout
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		#1; // let the write settle before the caller looks at outputs
	endtask : wr
	// read data stand only in the cycle after the strobe
	task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string n);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
		chk(n, e, rv & m);
	endtask : rc
	task automatic cmd(input logic [31:0] w0, input logic [31:0] w1, input logic [31:0] w2);
		wr(fpcc_pkg::REG_COB0, w0);
		wr(fpcc_pkg::REG_COB1, w1);
		wr(fpcc_pkg::REG_COB2, w2);
		wr(fpcc_pkg::REG_STAT, 32'h00000080);
	endtask : cmd
	// programmer polls completion instead of waiting a fixed time
	task automatic wait_ccf;
		int i;
		for (i = 0; i < 400; i++) begin
			rc(fpcc_pkg::REG_STAT, 32'h0, 32'h0, "poll");
			if (rv[fpcc_pkg::STAT_CCF] === 1'b1) break;
		end
		if (i == 400) timeout("ccf");
	endtask : wait_ccf
	// serial port byte, mode 0, msb first; 400 ns link period
	task automatic sp_byte(input logic [7:0] tx);
		for (int i = 7; i >= 0; i--) begin
			sp_din <= tx[i];
			repeat (4) @(posedge sys_clk);
			sb[i] = sp_dout; // master samples at its rising edge
			sb_oe = sp_dout_oe;
			sp_clk <= 1'b1;
			repeat (4) @(posedge sys_clk);
			sp_clk <= 1'b0;
		end
	endtask : sp_byte
	task automatic sp_frame(input logic [7:0] op, input int n, input logic [95:0] pl);
		@(posedge sys_clk);
		sp_cs_n <= 1'b0;
		repeat (4) @(posedge sys_clk);
		sp_byte(op);
		for (int j = n - 1; j >= 0; j--) sp_byte(pl[8 * j +: 8]);
		repeat (4) @(posedge sys_clk);
		sp_cs_n <= 1'b1;
		sp_din <= ~sp_din;
		repeat (8) @(posedge sys_clk);
	endtask : sp_frame
	task automatic do_reset;
		srst <= 1'b1;
		repeat (8) @(posedge sys_clk);
		srst <= 1'b0;
		repeat (10) @(posedge sys_clk);
	endtask : do_reset
	// main sequence
	initial begin
		srst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		sp_mode = 1'b0;
		sp_cs_n = 1'b1;
		sp_clk = 1'b0;
		sp_din = 1'b0;
		delay = 8'h14;
		n_errors = 0;
		num_checks = 0;
		n_starts = 0;
		do_reset();
		chk("prot", 32'h000000f0, prot_ctrl);
		chk("sec", 32'h5a, 32'(sec_ctrl));
		rc(fpcc_pkg::REG_CFG3, 32'hffffffff, 32'hffffff5a, "cfg3");
		rc(fpcc_pkg::REG_PART, 32'hffffffff, 32'hffffffff, "part");
		chk("part_en", 32'h0, 32'(eeprom_part_en));
		$display("test reset load done");
		wr(fpcc_pkg::REG_IRQ_EN, 32'h0);
		cmd({fpcc_pkg::CMD_PGM_PHRASE, fpcc_pkg::CFG_BASE}, 32'hffffffff, 32'hffffffff);
		rc(fpcc_pkg::REG_STAT, 32'h80, 32'h0, "ccf busy");
		wait_ccf();
		chk("kind", 32'(fpcc_pkg::FOP_PROG), 32'(k_last));
		chk("len", 32'(fpcc_pkg::PHRASE_WORDS), 32'(l_last));
		chk("ram", 32'h0, 32'(u_last));
		chk("data", 32'hffffffff, d_last[31:0] & d_last[63:32]);
		chk("irq masked", 32'h0, 32'(irq));
		rc(fpcc_pkg::REG_IRQ_ST, 32'h1, 32'h1, "irq done");
		wr(fpcc_pkg::REG_IRQ_EN, 32'h1);
		chk("irq on", 32'h1, 32'(irq));
		wr(fpcc_pkg::REG_IRQ_CLR, 32'h1);
		chk("irq clr", 32'h0, 32'(irq));
		cmd({fpcc_pkg::CMD_PGM_PHRASE, fpcc_pkg::CFG_BASE + 24'h8}, 32'hffffffff, 32'hfffffffe);
		wait_ccf();
		chk("prot held", 32'h000000f0, prot_ctrl);
		chk("sec held", 32'h5a, 32'(sec_ctrl));
		do_reset();
		chk("prot new", 32'hffffffff, prot_ctrl);
		chk("sec new", 32'hfe, 32'(sec_ctrl));
		$display("test phrase and config done");
		cmd({fpcc_pkg::CMD_PGM_LONG, 24'h001000}, 32'h0, 32'h0);
		rc(fpcc_pkg::REG_STAT, 32'ha0, 32'ha0, "long refused");
		wr(fpcc_pkg::REG_STAT, 32'h00000020);
		wr(fpcc_pkg::REG_CTRL, 32'h1);
		cmd({fpcc_pkg::CMD_PGM_SECT, 24'h001000}, 32'h0, 32'h0);
		rc(fpcc_pkg::REG_STAT, 32'ha0, 32'ha0, "sect eeprom");
		chk("no start", 32'h2, 32'(n_starts));
		wr(fpcc_pkg::REG_STAT, 32'h00000020);
		wr(fpcc_pkg::REG_CTRL, 32'h0);
		delay = 8'h02;
		cmd({fpcc_pkg::CMD_PGM_SECT, 24'h001000}, 32'h0, 32'h0);
		wait_ccf();
		chk("sect len", 32'(fpcc_pkg::SECT_WORDS), 32'(l_last));
		chk("sect ram", 32'h1, 32'(u_last));
		chk("sect addr", 32'h00001000, 32'(a_last));
		rc(8'h3c, 32'hffffffff, 32'h0, "unmapped");
		rc(fpcc_pkg::REG_IRQ_CLR, 32'hffffffff, 32'h0, "wo reg");
		$display("test refusals and section done");
		wr(fpcc_pkg::REG_CTRL, 32'h1);
		sp_mode <= 1'b1;
		repeat (10) @(posedge sys_clk);
		chk("port mode", 32'h0, 32'(ram_eeprom_mode));
		wr(fpcc_pkg::REG_CTRL, 32'h1);
		sp_frame(fpcc_pkg::SP_OP_SECT, 3, 96'h002000);
		rc(fpcc_pkg::REG_IRQ_ST, 32'h4, 32'h4, "port reject");
		chk("no port start", 32'h3, 32'(n_starts));
		wr(fpcc_pkg::REG_CTRL, 32'h0);
		delay = 8'hc8;
		sp_frame(fpcc_pkg::SP_OP_SECT, 3, 96'h002000);
		sp_frame(fpcc_pkg::SP_OP_RDSR, 1, 96'h0);
		chk("wip set", 32'h1, 32'(sb[0]));
		chk("port oe", 32'h1, 32'(sb_oe));
		chk("port ram", 32'h1, 32'(u_last));
		for (int i = 0; i < 20 && sb[0] !== 1'b0; i++) sp_frame(fpcc_pkg::SP_OP_RDSR, 1, 96'h0);
		chk("wip clear", 32'h0, 32'(sb[0]));
		delay = 8'h05;
		sp_frame(fpcc_pkg::SP_OP_WRCOB, 12, {fpcc_pkg::CMD_PART, 24'h0, 32'h23, 32'h05});
		wait_ccf();
		chk("erase first", 32'(fpcc_pkg::FOP_ERASE_NVM), 32'(k_prev));
		chk("format", 32'(fpcc_pkg::FOP_FORMAT), 32'(k_last));
		rc(fpcc_pkg::REG_PART, 32'hffffffff, 32'h23, "part code");
		chk("part on", 32'h1, 32'(eeprom_part_en));
		cmd({fpcc_pkg::CMD_MASS, 24'h0}, 32'h0, 32'h0);
		wait_ccf();
		chk("mass", 32'(fpcc_pkg::FOP_ERASE_ALL), 32'(k_last));
		rc(fpcc_pkg::REG_PART, 32'hffffffff, 32'hffffffff, "part gone");
		chk("part off", 32'h0, 32'(eeprom_part_en));
		$display("test serial port done");
		summarize();
	end
endmodule : tb_fpcc_top
